// file: dv/iod_decoder_sva.sv
// assertions on the decoder ports
`timescale 1ns/1ps
module iod_decoder_sva
(
	input wire        REF_CLK,
	input wire        RESETN,
	input wire        DEC_VALID,
	input wire [7:0]  MODRM,
	input wire [7:0]  DISP_LO,
	input wire        OUT_VALID,
	input wire [15:0] OP_CLASS,
	input wire        IS_WORD,
	input wire        RM_IS_REG,
	input wire        MEM_OPERAND,
	input wire [2:0]  REG_SEL,
	input wire [1:0]  DISP_BYTES,
	input wire [15:0] DISP,
	input wire [7:0]  REG_NAME
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);
	a_answer_next: assert property (DEC_VALID |=> OUT_VALID)
		else $error("decode gave no answer");
	a_no_stray: assert property (!DEC_VALID |=> !OUT_VALID)
		else $error("answer without request");
	a_class_hold: assert property (!DEC_VALID |=> $stable(OP_CLASS))
		else $error("class changed while idle");
	a_reg_mode: assert property (DEC_VALID
		|=> RM_IS_REG == ($past(MODRM[7:6]) == 2'h3))
		else $error("register mode wrong");
	a_mem_inverse: assert property (OUT_VALID
		|-> MEM_OPERAND == ($past(MODRM[7:6]) != 2'h3))
		else $error("memory flag wrong");
	a_disp_count: assert property (DEC_VALID && MODRM[7:6] != 2'h3
		|=> DISP_BYTES == $past(MODRM[7:6]))
		else $error("displacement count wrong");
	a_disp_sext: assert property (DEC_VALID && MODRM[7:6] == 2'h1
		|=> DISP == {{8{$past(DISP_LO[7])}}, $past(DISP_LO)})
		else $error("short displacement wrong");
	a_reg_index: assert property (OUT_VALID && RM_IS_REG && OP_CLASS == 16'h0800
		|-> REG_NAME == {4'h0, IS_WORD, $past(MODRM[2:0])})
		else $error("register name wrong");
endmodule
bind iod_decoder iod_decoder_sva u_sva (.REF_CLK, .RESETN, .DEC_VALID, .MODRM, .DISP_LO,
	.OUT_VALID, .OP_CLASS, .IS_WORD, .RM_IS_REG, .MEM_OPERAND, .REG_SEL, .DISP_BYTES,
	.DISP, .REG_NAME);

// file: dv/iod_fetch.sv
// fetch stage model that hands bytes to the decoder
`timescale 1ns/1ps
module iod_fetch
(
	input  wire        clk,
	input  wire        go,
	input  wire [40:0] bytes_in,
	output reg         valid,
	output reg  [40:0] bytes_out
);
	// idle lines invert on every idle cycle, so every second idle cycle shows the stale copy again
	always @(posedge clk)
	begin
		valid <= go;
		bytes_out <= go ? bytes_in : ~bytes_out;
	end
endmodule

// file: dv/tb_iod_decoder.sv
// self-checking bench for the operand and opcode decoder
`timescale 1ns/1ps
module tb_iod_decoder;
	reg         REF_CLK = 1'b0;
	reg         RESETN = 1'b0;
	reg         go = 1'b0;
	reg  [40:0] req = 41'h0;
	integer     miscompares = 0;
	integer     samples_checked = 0;
	integer     cyc = 0;
	integer     i;
	integer     a;
	wire        f_v;
	wire [40:0] f;
	wire        OUT_VALID, IS_WORD, RM_IS_REG, MEM_OPERAND, ROT_RIGHT, ILLEGAL;
	wire [15:0] OP_CLASS, DISP, IMM_EXT;
	wire [7:0]  CYC_BASE, CYC_PER_REP, REG_NAME;
	wire [4:0]  ROT_WIDTH;
	wire [2:0]  REG_SEL, SEG_SEL;
	wire [1:0]  DISP_BYTES, ROT_CNT_SRC, FLAG_MODE;
	wire [7:0]  cyc_base8;
	iod_fetch fetch (.clk(REF_CLK), .go(go), .bytes_in(req), .valid(f_v), .bytes_out(f));
	iod_decoder uut (.REF_CLK, .RESETN, .DEC_VALID(f_v), .REP_PREFIX(f[40]),
		.OPCODE(f[39:32]), .MODRM(f[31:24]), .DISP_LO(f[23:16]), .DISP_HI(f[15:8]),
		.IMM8(f[7:0]), .OUT_VALID, .OP_CLASS, .IS_WORD, .RM_IS_REG, .MEM_OPERAND,
		.REG_SEL, .SEG_SEL, .DISP_BYTES, .DISP, .IMM_EXT, .ROT_RIGHT, .ROT_CNT_SRC,
		.ROT_WIDTH, .CYC_BASE, .CYC_PER_REP, .FLAG_MODE, .REG_NAME, .ILLEGAL);
	// second copy with the 8-bit bus cycle figures
	iod_decoder #(.BUS8(1)) uut8 (.REF_CLK(REF_CLK), .RESETN(RESETN), .DEC_VALID(f_v),
		.REP_PREFIX(f[40]), .OPCODE(f[39:32]), .MODRM(f[31:24]), .DISP_LO(f[23:16]),
		.DISP_HI(f[15:8]), .IMM8(f[7:0]), .OUT_VALID(), .OP_CLASS(), .IS_WORD(),
		.RM_IS_REG(), .MEM_OPERAND(), .REG_SEL(), .SEG_SEL(), .DISP_BYTES(), .DISP(),
		.IMM_EXT(), .ROT_RIGHT(), .ROT_CNT_SRC(), .ROT_WIDTH(), .CYC_BASE(cyc_base8),
		.CYC_PER_REP(), .FLAG_MODE(), .REG_NAME(), .ILLEGAL());
	always #2.5 REF_CLK = ~REF_CLK;
	task stop_test;
		begin
			$display("checks %0d miscompares %0d", samples_checked, miscompares);
			if (miscompares == 0 && samples_checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task chk(input [47:0] got, input [47:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp)
			begin
				miscompares = miscompares + 1;
				$display("ERROR %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// one request through the fetch stage, wait for the answer
	task run(input [40:0] r);
		integer n;
		begin
			@(posedge REF_CLK);
			req <= r;
			go <= 1'b1;
			@(posedge REF_CLK);
			go <= 1'b0;
			#1;
			n = 0;
			while (OUT_VALID !== 1'b1 && n < 8)
			begin
				@(posedge REF_CLK);
				#1;
				n = n + 1;
			end
			chk(OUT_VALID, 1'b1);
		end
	endtask
	task sc(input [7:0] op, input [7:0] m, input [15:0] cls);
		begin
			run({1'b0, op, m, 24'hff_80_85});
			chk(OP_CLASS, cls);
		end
	endtask
	task sg(input [7:0] op, input [15:0] cls, input [2:0] seg);
		begin
			sc(op, 8'h00, cls);
			chk(SEG_SEL, seg);
		end
	endtask
	task t_modrm;
		begin
			run({1'b0, 32'h8f_07_12_34, 8'h00});
			chk({DISP_BYTES, DISP, MEM_OPERAND}, {2'h0, 16'h0000, 1'b1});
			run({1'b0, 32'h8f_45_80_34, 8'h00});
			chk({DISP_BYTES, DISP}, {2'h1, 16'hff80});
			run({1'b0, 32'h8f_86_12_34, 8'h00});
			chk({DISP_BYTES, DISP, OP_CLASS}, {2'h2, 16'h3412, 16'h0001});
			run({1'b0, 32'h8f_c5_12_34, 8'h00});
			chk({RM_IS_REG, REG_SEL, DISP}, {1'b1, 3'h5, 16'h0000});
			run({1'b0, 32'h8f_48_00_00, 8'h00});
			chk(ILLEGAL, 1'b1);
		end
	endtask
	task t_regs;
		begin
			for (i = 0; i < 8; i = i + 1)
			begin
				sc(8'h58 + i[7:0], 8'h00, 16'h0002);
				chk({REG_NAME, CYC_BASE}, {5'h01, i[2:0], 8'h0a});
				sc(8'h50 + i[7:0], 8'h00, 16'h0008);
				chk(REG_NAME, {5'h01, i[2:0]});
				sc(8'hd0, {5'h1a, i[2:0]}, 16'h0800);
				chk(REG_NAME, {5'h00, i[2:0]});
			end
		end
	endtask
	task t_stack;
		begin
			sg(8'h1f, 16'h0004, 3'h3);
			sg(8'h07, 16'h0004, 3'h0);
			sg(8'h17, 16'h0004, 3'h2);
			sg(8'h0e, 16'h0040, 3'h1);
			chk(CYC_BASE, 8'h09);
			sg(8'h16, 16'h0040, 3'h2);
			sg(8'h1e, 16'h0040, 3'h3);
			sg(8'h06, 16'h0040, 3'h0);
			chk(CYC_BASE, 8'h09);
			sc(8'h60, 8'h00, 16'h0080);
			chk(CYC_BASE, 8'h24);
			chk(cyc_base8, 8'h44);
			sc(8'h61, 8'h00, 16'h0100);
			chk(CYC_BASE, 8'h33);
			chk(cyc_base8, 8'h53);
			sc(8'h9c, 8'h00, 16'h0200);
			chk(FLAG_MODE, 2'h0);
			sc(8'h9d, 8'h00, 16'h0400);
			chk(FLAG_MODE, 2'h2);
			sc(8'h68, 8'h00, 16'h0020);
			chk(IMM_EXT, 16'h80ff);
			sc(8'h6a, 8'h00, 16'h0020);
			chk(IMM_EXT, 16'hff85);
			sc(8'hff, 8'h36, 16'h0010);
			sc(8'hff, 8'h06, 16'h0000);
		end
	endtask
	task t_rot;
		begin
			for (i = 0; i < 6; i = i + 1)
				for (a = 0; a < 4; a = a + 1)
				begin
					sc(i < 4 ? 8'hd0 + i[7:0] : 8'hbc + i[7:0],
						{a[1] ? 2'h0 : 2'h3, 2'h1, a[0], 3'h1}, 16'h0800);
					chk({ROT_RIGHT, ROT_CNT_SRC, ROT_WIDTH, IS_WORD, CYC_BASE}, {a[0], i[2:1],
						i[0] ? 5'd17 : 5'd9, i[0], a[1] ? 8'h0f : 8'h02});
					chk(IMM_EXT, 16'h0085);
				end
		end
	endtask
	task t_str;
		begin
			run({1'b1, 32'h6c_00_00_00, 8'h00});
			chk({OP_CLASS, CYC_BASE, CYC_PER_REP, ILLEGAL}, {16'h1000, 8'h08, 8'h08, 1'b0});
			run({1'b1, 32'hac_00_00_00, 8'h00});
			chk({OP_CLASS, CYC_BASE, CYC_PER_REP}, {16'h2000, 8'h06, 8'h0b});
			run({1'b1, 32'had_00_00_00, 8'h00});
			chk({OP_CLASS, IS_WORD}, {16'h2000, 1'b1});
			run({1'b0, 32'h6c_00_00_00, 8'h00});
			chk(ILLEGAL, 1'b1);
		end
	endtask
	always @(posedge REF_CLK)
	begin
		cyc = cyc + 1;
		if (cyc == 3000)
		begin
			miscompares = miscompares + 1;
			stop_test;
		end
	end
	initial
	begin
		repeat (8) @(posedge REF_CLK);
		RESETN <= 1'b1;
		#1;
		chk({OUT_VALID, OP_CLASS, DISP_BYTES, DISP}, 35'h0);
		t_modrm;
		t_regs;
		t_stack;
		t_rot;
		t_str;
		stop_test;
	end
endmodule

// file: verilog/iod_decoder.v
// instruction operand and opcode decoder for stack, rotate and string ops
// What this block does
// [RULE1] split operand byte into mod 7:6, aux 5:3, r/m 2:0
// [RULE2] mod 11 makes r/m a register selector
// [RULE3] mod 00 no disp, 01 sign-extended byte, 10 high:low word
// [RULE4] byte registers AL CL DL BL AH CH DH BH for codes 000..111
// [RULE5] word registers AX CX DX BX SP BP SI DI for codes 000..111
// [RULE6] 8F/0 pops to memory; 58+r pops to register in 10 cycles
// [RULE7] 1F, 07, 17 pop into DS, ES, SS
// [RULE8] 50+r push register, FF/6 push memory, 68 push imm16
// [RULE9] 6A pushes sign-extended imm8
// [RULE10] 0E 16 1E 06 push CS SS DS ES in 9 cycles
// [RULE11] 60 pushes all eight words, 36 or 68 cycles
// [RULE12] 61 pops all words, 51 or 83 cycles
// [RULE13] 9C pushes flags, 9D pops flags
// [RULE14] D0 D2 C0 aux 2 rotate byte left through carry
// [RULE15] D1 D3 C1 aux 2 rotate word left through carry
// [RULE16] aux 3 rotates right; single step 2 reg, 15 memory
// [RULE17] F3 6C inputs CX bytes port DX, 8+8n cycles
// [RULE18] F3 AC/AD load CX bytes/words, byte form 6+11n
// [RULE19] flag codes undefined, unchanged, result-dependent drive execution
// [RULE20] mod not 11 makes aux opcode-specific, r/m a memory operand
`timescale 1ns/1ps
`include "iod_map.vh"
module iod_decoder
#(
	parameter BUS8 = 0
)
(
	input  wire        REF_CLK,
	input  wire        RESETN,
	input  wire        DEC_VALID,
	input  wire        REP_PREFIX,
	input  wire [7:0]  OPCODE,
	input  wire [7:0]  MODRM,
	input  wire [7:0]  DISP_LO,
	input  wire [7:0]  DISP_HI,
	input  wire [7:0]  IMM8,
	output reg         OUT_VALID,
	output reg  [15:0] OP_CLASS,
	output reg         IS_WORD,
	output reg         RM_IS_REG,
	output reg         MEM_OPERAND,
	output reg  [2:0]  REG_SEL,
	output reg  [2:0]  SEG_SEL,
	output reg  [1:0]  DISP_BYTES,
	output reg  [15:0] DISP,
	output reg  [15:0] IMM_EXT,
	output reg         ROT_RIGHT,
	output reg  [1:0]  ROT_CNT_SRC,
	output reg  [4:0]  ROT_WIDTH,
	output reg  [7:0]  CYC_BASE,
	output reg  [7:0]  CYC_PER_REP,
	output reg  [1:0]  FLAG_MODE,
	output reg  [7:0]  REG_NAME,
	output reg         ILLEGAL
);
	// one-hot operation classes
	localparam C_POPM  = 16'h0001;
	localparam C_POPR  = 16'h0002;
	localparam C_POPS  = 16'h0004;
	localparam C_PUSHR = 16'h0008;
	localparam C_PUSHM = 16'h0010;
	localparam C_PUSHI = 16'h0020;
	localparam C_PUSHS = 16'h0040;
	localparam C_PUSHA = 16'h0080;
	localparam C_POPA  = 16'h0100;
	localparam C_PUSHF = 16'h0200;
	localparam C_POPF  = 16'h0400;
	localparam C_ROT   = 16'h0800;
	localparam C_INS   = 16'h1000;
	localparam C_LODS  = 16'h2000;
	localparam C_NONE  = 16'h0000;
	localparam [1:0] CNT_ONE = 2'h0;
	localparam [1:0] CNT_CL  = 2'h1;
	localparam [1:0] CNT_IMM = 2'h2;
	localparam [2:0] SEG_ES = 3'h0;
	localparam [2:0] SEG_CS = 3'h1;
	localparam [2:0] SEG_SS = 3'h2;
	localparam [2:0] SEG_DS = 3'h3;

	wire [2:0]  aux_f;
	wire [2:0]  rm_f;
	wire        rm_reg;
	wire [1:0]  dbytes;
	wire [15:0] dval;

	reg  [15:0] cls_nxt;
	reg         word_nxt;
	reg  [2:0]  reg_nxt;
	reg  [2:0]  seg_nxt;
	reg  [15:0] imm_nxt;
	reg         right_nxt;
	reg  [1:0]  cnt_nxt;
	reg  [7:0]  base_nxt;
	reg  [7:0]  rep_nxt;
	reg  [1:0]  flag_nxt;

	iod_modrm u_modrm
	(
		.modrm      (MODRM),
		.disp_lo    (DISP_LO),
		.disp_hi    (DISP_HI),
		.mod_f      (),
		.aux_f      (aux_f),
		.rm_f       (rm_f),
		.rm_is_reg  (rm_reg),
		.disp_bytes (dbytes),
		.disp       (dval)
	);

	// register name code: byte set then word set, ascii-free index 0..15
	function [7:0] reg_name;
		input [2:0] code;
		input       wide;
		begin
			reg_name = {4'h0, wide, code};
		end
	endfunction

	always @*
	begin
		cls_nxt   = C_NONE;
		word_nxt  = 1'b1;
		reg_nxt   = rm_f;
		seg_nxt   = SEG_DS;
		imm_nxt   = 16'h0000;
		right_nxt = 1'b0;
		cnt_nxt   = CNT_ONE;
		base_nxt  = 8'h00;
		rep_nxt   = 8'h00;
		flag_nxt  = `IOD_FLAG_UNCH;
		case (OPCODE)
			// [RULE6] pop to memory word
			`IOD_OP_POPM:
				if (aux_f == `IOD_AUX_POP)
					cls_nxt = C_POPM;
			// [RULE7] pop segment registers
			`IOD_OP_POPDS:
			begin
				cls_nxt = C_POPS;
				seg_nxt = SEG_DS;
			end
			`IOD_OP_POPES:
			begin
				cls_nxt = C_POPS;
				seg_nxt = SEG_ES;
			end
			`IOD_OP_POPSS:
			begin
				cls_nxt = C_POPS;
				seg_nxt = SEG_SS;
			end
			// [RULE8] push memory and immediate word
			`IOD_OP_GRPFF:
				if (aux_f == `IOD_AUX_PUSH)
					cls_nxt = C_PUSHM;
			`IOD_OP_PUSHI16:
			begin
				cls_nxt = C_PUSHI;
				imm_nxt = {DISP_HI, DISP_LO};
			end
			// [RULE9] sign-extended imm8 push
			`IOD_OP_PUSHI8:
			begin
				cls_nxt = C_PUSHI;
				imm_nxt = {{8{IMM8[7]}}, IMM8};
			end
			// [RULE10] push segment registers
			`IOD_OP_PUSHCS, `IOD_OP_PUSHSS, `IOD_OP_PUSHDS, `IOD_OP_PUSHES:
			begin
				cls_nxt  = C_PUSHS;
				base_nxt = `IOD_CYC_PUSHSEG;
				seg_nxt  = (OPCODE == `IOD_OP_PUSHCS) ? SEG_CS :
					(OPCODE == `IOD_OP_PUSHSS) ? SEG_SS :
					(OPCODE == `IOD_OP_PUSHDS) ? SEG_DS : SEG_ES;
			end
			// [RULE11] push all
			`IOD_OP_PUSHALL:
			begin
				cls_nxt  = C_PUSHA;
				base_nxt = BUS8 ? `IOD_CYC_PUSHA8 : `IOD_CYC_PUSHA16;
			end
			// [RULE12] pop all
			`IOD_OP_POPALL:
			begin
				cls_nxt  = C_POPA;
				base_nxt = BUS8 ? `IOD_CYC_POPA8 : `IOD_CYC_POPA16;
			end
			// [RULE13] flags push and pop
			`IOD_OP_PUSHFL:
				cls_nxt = C_PUSHF;
			`IOD_OP_POPFL:
			begin
				cls_nxt  = C_POPF;
				flag_nxt = `IOD_FLAG_RES;
			end
			// [RULE14] [RULE15] [RULE16] rotate through carry
			`IOD_OP_ROT1B, `IOD_OP_ROT1W, `IOD_OP_ROTCLB, `IOD_OP_ROTCLW,
			`IOD_OP_ROTIB, `IOD_OP_ROTIW:
				if (aux_f == `IOD_AUX_RCL || aux_f == `IOD_AUX_RCR)
				begin
					cls_nxt   = C_ROT;
					word_nxt  = OPCODE[0];
					right_nxt = (aux_f == `IOD_AUX_RCR);
					cnt_nxt   = (OPCODE[7:4] == 4'hc) ? CNT_IMM :
						OPCODE[1] ? CNT_CL : CNT_ONE;
					imm_nxt   = {8'h00, IMM8};
					base_nxt  = rm_reg ? `IOD_CYC_ROTREG : `IOD_CYC_ROTMEM;
				end
			// [RULE17] repeated byte input
			`IOD_OP_INSB:
				if (REP_PREFIX)
				begin
					cls_nxt  = C_INS;
					word_nxt = 1'b0;
					seg_nxt  = SEG_ES;
					base_nxt = `IOD_CYC_INS_B;
					rep_nxt  = `IOD_CYC_INS_N;
				end
			// [RULE18] repeated load
			`IOD_OP_LODB, `IOD_OP_LODW:
				if (REP_PREFIX)
				begin
					cls_nxt  = C_LODS;
					word_nxt = OPCODE[0];
					base_nxt = `IOD_CYC_LOD_B;
					rep_nxt  = `IOD_CYC_LOD_N;
				end
			default:
			begin
				// [RULE6] [RULE8] register pop and push
				if ({OPCODE[7:3], 3'h0} == `IOD_OP_POPR)
				begin
					cls_nxt  = C_POPR;
					reg_nxt  = OPCODE[2:0];
					base_nxt = `IOD_CYC_POPR;
				end
				else if ({OPCODE[7:3], 3'h0} == `IOD_OP_PUSHR)
				begin
					cls_nxt = C_PUSHR;
					reg_nxt = OPCODE[2:0];
				end
			end
		endcase
	end

	always @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			OUT_VALID   <= 1'b0;
			OP_CLASS    <= C_NONE;
			IS_WORD     <= 1'b0;
			RM_IS_REG   <= 1'b0;
			MEM_OPERAND <= 1'b0;
			REG_SEL     <= 3'h0;
			SEG_SEL     <= 3'h0;
			DISP_BYTES  <= 2'h0;
			DISP        <= 16'h0000;
			IMM_EXT     <= 16'h0000;
			ROT_RIGHT   <= 1'b0;
			ROT_CNT_SRC <= 2'h0;
			ROT_WIDTH   <= 5'h00;
			CYC_BASE    <= 8'h00;
			CYC_PER_REP <= 8'h00;
			FLAG_MODE   <= 2'h0;
			REG_NAME    <= 8'h00;
			ILLEGAL     <= 1'b0;
		end
		else
		begin
			OUT_VALID <= DEC_VALID;
			if (DEC_VALID)
			begin
				OP_CLASS    <= cls_nxt;
				IS_WORD     <= word_nxt;
				// [RULE2] [RULE20] register versus memory operand
				RM_IS_REG   <= rm_reg;
				MEM_OPERAND <= !rm_reg;
				REG_SEL     <= reg_nxt;
				SEG_SEL     <= seg_nxt;
				// [RULE3] latched displacement
				DISP_BYTES  <= rm_reg ? 2'h0 : dbytes;
				DISP        <= rm_reg ? 16'h0000 : dval;
				IMM_EXT     <= imm_nxt;
				ROT_RIGHT   <= right_nxt;
				ROT_CNT_SRC <= cnt_nxt;
				ROT_WIDTH   <= word_nxt ? 5'h11 : 5'h09;
				CYC_BASE    <= base_nxt;
				CYC_PER_REP <= rep_nxt;
				// [RULE19] flag effect code
				FLAG_MODE   <= flag_nxt;
				// [RULE4] [RULE5] byte or word register naming
				REG_NAME    <= reg_name(reg_nxt, word_nxt);
				ILLEGAL     <= (cls_nxt == C_NONE);
			end
		end
	end
endmodule

// file: verilog/iod_map.vh
// constants for the operand and opcode decoder
`ifndef IOD_MAP_VH
`define IOD_MAP_VH
`define IOD_MOD_HI      7
`define IOD_MOD_LO      6
`define IOD_AUX_HI      5
`define IOD_AUX_LO      3
`define IOD_RM_HI       2
`define IOD_RM_LO       0
`define IOD_MOD_NODISP  2'h0
`define IOD_MOD_DISP8   2'h1
`define IOD_MOD_DISP16  2'h2
`define IOD_MOD_REG     2'h3
`define IOD_OP_POPM     8'h8f
`define IOD_OP_POPR     8'h58
`define IOD_OP_POPDS    8'h1f
`define IOD_OP_POPES    8'h07
`define IOD_OP_POPSS    8'h17
`define IOD_OP_PUSHR    8'h50
`define IOD_OP_GRPFF    8'hff
`define IOD_OP_PUSHI16  8'h68
`define IOD_OP_PUSHI8   8'h6a
`define IOD_OP_PUSHCS   8'h0e
`define IOD_OP_PUSHSS   8'h16
`define IOD_OP_PUSHDS   8'h1e
`define IOD_OP_PUSHES   8'h06
`define IOD_OP_PUSHALL  8'h60
`define IOD_OP_POPALL   8'h61
`define IOD_OP_PUSHFL   8'h9c
`define IOD_OP_POPFL    8'h9d
`define IOD_OP_ROT1B    8'hd0
`define IOD_OP_ROT1W    8'hd1
`define IOD_OP_ROTCLB   8'hd2
`define IOD_OP_ROTCLW   8'hd3
`define IOD_OP_ROTIB    8'hc0
`define IOD_OP_ROTIW    8'hc1
`define IOD_OP_REP      8'hf3
`define IOD_OP_INSB     8'h6c
`define IOD_OP_LODB     8'hac
`define IOD_OP_LODW     8'had
`define IOD_AUX_POP     3'h0
`define IOD_AUX_PUSH    3'h6
`define IOD_AUX_RCL     3'h2
`define IOD_AUX_RCR     3'h3
`define IOD_CYC_POPR    8'h0a
`define IOD_CYC_PUSHSEG 8'h09
`define IOD_CYC_PUSHA16 8'h24
`define IOD_CYC_PUSHA8  8'h44
`define IOD_CYC_POPA16  8'h33
`define IOD_CYC_POPA8   8'h53
`define IOD_CYC_ROTREG  8'h02
`define IOD_CYC_ROTMEM  8'h0f
`define IOD_CYC_INS_B   8'h08
`define IOD_CYC_INS_N   8'h08
`define IOD_CYC_LOD_B   8'h06
`define IOD_CYC_LOD_N   8'h0b
`define IOD_FLAG_UNCH   2'h0
`define IOD_FLAG_UNDEF  2'h1
`define IOD_FLAG_RES    2'h2
`endif

// file: verilog/iod_modrm.v
// operand address byte splitter and displacement former
`timescale 1ns/1ps
`include "iod_map.vh"
module iod_modrm
(
	input  wire [7:0]  modrm,
	input  wire [7:0]  disp_lo,
	input  wire [7:0]  disp_hi,
	output wire [1:0]  mod_f,
	output wire [2:0]  aux_f,
	output wire [2:0]  rm_f,
	output wire        rm_is_reg,
	output reg  [1:0]  disp_bytes,
	output reg  [15:0] disp
);
	// [RULE1] field split
	assign mod_f = modrm[`IOD_MOD_HI:`IOD_MOD_LO];
	assign aux_f = modrm[`IOD_AUX_HI:`IOD_AUX_LO];
	assign rm_f  = modrm[`IOD_RM_HI:`IOD_RM_LO];
	// [RULE2] register select
	assign rm_is_reg = (mod_f == `IOD_MOD_REG);
	// [RULE3] displacement forming
	always @*
	begin
		case (mod_f)
			`IOD_MOD_DISP8:
			begin
				disp_bytes = 2'h1;
				disp = {{8{disp_lo[7]}}, disp_lo};
			end
			`IOD_MOD_DISP16:
			begin
				disp_bytes = 2'h2;
				disp = {disp_hi, disp_lo};
			end
			default:
			begin
				disp_bytes = 2'h0;
				disp = 16'h0000;
			end
		endcase
	end
endmodule
